// [hw/tsc_ctrl.sv]
// dual channel controller: tape host and scsi initiator behind a processor
// assumes link pins are asynchronous; processor and dma logic share mclk
`timescale 1ns/1ps
module tsc_ctrl (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // processor commands
  input  wire logic       cmdWr,
  input  wire logic [7:0] cmdByte,
  input  wire logic       selWr,
  input  wire logic [7:0] selId,
  input  wire logic       tapeCmdWr,
  input  wire logic [7:0] tapeCmd,
  // processor feedback
  output logic            asyncReadyWait,
  output logic            irq,
  output logic [7:0]      irqStatus,
  output logic [7:0]      busStatus,
  // dma, channel 0 scsi, channel 1 tape
  output logic [1:0]      dmaReq,
  input  wire logic [1:0] dmaAck,
  input  wire logic [7:0] dmaWrData,
  output logic [7:0]      dmaRdData,
  // scsi bus, data bit 8 is parity
  input  wire logic [8:0] scsiDbIn,
  output logic [8:0]      scsiDbOut,
  output logic            scsiDbOe,
  input  wire logic       scsiBsyIn,
  input  wire logic       scsiReqIn,
  input  wire logic       scsiIoIn,
  input  wire logic       scsiMsgIn,
  input  wire logic       scsiCdIn,
  output logic            scsiSel,
  output logic            scsiAtn,
  output logic            scsiAck,
  output logic            scsiRst,
  // tape bus
  input  wire logic [7:0] tapeDbIn,
  output logic [7:0]      tapeDbOut,
  output logic            tapeDbOe,
  input  wire logic       tapeRdyIn,
  input  wire logic       tapeExcIn,
  input  wire logic       tapeAckIn,
  input  wire logic       tapeDirIn,
  output logic            tapeReq,
  output logic            tapeXfer,
  output logic            tapeOnline,
  output logic            tapeRst
);
  localparam int RstLast = tsc_pkg::RST_CYC - 1;

  function automatic logic oddPar(input logic [7:0] b);
    return ~^b;
  endfunction : oddPar

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [tsc_pkg::SYNC_W-1:0] syncA_q, syncB_q;
  logic       bsyS, reqS, ioS, msgS, cdS, rdyS, excS, ackS, dirS;
  logic [8:0] sDbS;
  logic [7:0] tDbS;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {scsiBsyIn, scsiReqIn, scsiIoIn, scsiMsgIn, scsiCdIn, tapeRdyIn,
                  tapeExcIn, tapeAckIn, tapeDirIn, scsiDbIn, tapeDbIn};
      syncB_q <= syncA_q;
    end
  end
  assign {bsyS, reqS, ioS, msgS, cdS, rdyS, excS, ackS, dirS, sDbS, tDbS} = syncB_q;
  assign busStatus = {bsyS, reqS, ioS, msgS, cdS, rdyS, excS, dirS};

  // ---------------------------------------------------------------------
  // inbound fifo and channel arbitration
  // ---------------------------------------------------------------------
  tsc_fifo_if #(.WIDTH(tsc_pkg::FIFO_WIDTH)) fq ();
  tsc_fifo #(.WIDTH(tsc_pkg::FIFO_WIDTH), .DEPTH(tsc_pkg::FIFO_DEPTH)) uFifo (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .p       (fq.fifo)
  );

  tsc_pkg::tsc_scsi_e sSt_q, sSt_d;
  tsc_pkg::tsc_tape_e tSt_q, tSt_d;
  logic sPushReq, tPushReq, sGnt, tGnt, favorTape_q, favorTape_d;
  logic inb0, inb1, sOutNeed, tOutNeed;
  logic atn_q, atn_d, online_q, online_d, tapeRst_q, tapeRst_d, xferEn_q, xferEn_d;
  logic rdyIntEn_q, rdyIntEn_d, rdyPrev_q, excPrev_q, excPend_q, excPend_d;

  assign sPushReq = sSt_q == tsc_pkg::S_WAITREQ && bsyS && reqS && ioS;
  assign tPushReq = tSt_q == tsc_pkg::T_RDACK && ackS;
  // alternate when both channels want the fifo in one cycle
  assign sGnt = sPushReq && fq.inReady && (!tPushReq || !favorTape_q);
  assign tGnt = tPushReq && fq.inReady && !sGnt;
  assign fq.inValid = sGnt || tGnt;
  assign fq.inData  = sGnt ? {1'b0, sDbS[7:0]} : {1'b1, tDbS};
  assign inb0 = fq.outValid && !fq.outData[8];
  assign inb1 = fq.outValid && fq.outData[8];
  assign fq.outReady = (inb0 && dmaAck[0]) || (inb1 && dmaAck[1]);
  assign dmaRdData   = fq.outData[7:0];
  assign sOutNeed = sSt_q == tsc_pkg::S_WAITREQ && bsyS && reqS && !ioS && !inb0;
  assign tOutNeed = tSt_q == tsc_pkg::T_IDLE && xferEn_q && rdyS && !dirS && !inb1
                    && !excPend_q && !tapeRst_q;
  assign dmaReq = {inb1 || tOutNeed, inb0 || sOutNeed};

  always_comb begin
    favorTape_d = favorTape_q;
    if (sGnt) begin
      favorTape_d = 1'b1;
    end else if (tGnt) begin
      favorTape_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // processor command decode and status
  // ---------------------------------------------------------------------
  logic [tsc_pkg::IRQ_W-1:0] irqSt_q, irqSt_d;
  logic [7:0] rstCnt_q, rstCnt_d;
  logic       cmdSet, selTake, tCmdTake, scsiDone, parErr, msgHit;
  logic [2:0] cmdSel;

  assign cmdSel   = cmdByte[2:0];
  assign cmdSet   = cmdByte[tsc_pkg::CMD_SET_BIT];
  assign selTake  = selWr && sSt_q == tsc_pkg::S_IDLE && rstCnt_q == '0;
  assign tCmdTake = tapeCmdWr && tSt_q == tsc_pkg::T_IDLE && !excPend_q && !tapeRst_q;
  // hold the processor in wait states until its write can be taken
  assign asyncReadyWait = (selWr && !selTake) || (tapeCmdWr && !tCmdTake);
  assign irqStatus = {3'h0, irqSt_q};
  assign irq       = |irqSt_q;
  assign scsiAtn   = atn_q;
  assign scsiRst   = rstCnt_q != '0;
  assign tapeOnline = online_q;
  assign tapeRst   = tapeRst_q;

  always_comb begin
    atn_d      = atn_q;
    online_d   = online_q;
    tapeRst_d  = tapeRst_q;
    xferEn_d   = xferEn_q;
    rdyIntEn_d = rdyIntEn_q;
    irqSt_d    = irqSt_q;
    excPend_d  = excPend_q;
    rstCnt_d   = rstCnt_q != '0 ? rstCnt_q - 8'h01 : 8'h00;
    if (cmdWr) begin
      unique case (cmdSel)
        tsc_pkg::CMD_ATN:      atn_d = cmdSet;
        tsc_pkg::CMD_SCSI_RST: if (cmdSet) rstCnt_d = 8'(tsc_pkg::RST_CYC);
        tsc_pkg::CMD_ONLINE:   online_d = cmdSet;
        tsc_pkg::CMD_TAPE_RST: tapeRst_d = cmdSet;
        tsc_pkg::CMD_XFER_EN: begin
          xferEn_d = cmdSet;
          if (cmdSet) online_d = 1'b0;
        end
        tsc_pkg::CMD_RDY_INT:  rdyIntEn_d = cmdSet;
        tsc_pkg::CMD_CLR_INT:  if (cmdSet) irqSt_d = '0;
        default: ;
      endcase
    end
    // events set after the clear so a same-cycle event is kept
    if (excS && !excPrev_q) begin
      excPend_d = 1'b1;
      irqSt_d[tsc_pkg::IRQ_TAPE_EXC] = 1'b1;
    end
    if (tSt_q == tsc_pkg::T_IDLE && excPend_q && !tapeRst_q) excPend_d = 1'b0;
    if (tapeRst_q) excPend_d = 1'b0;
    if (rdyIntEn_q && rdyS && !rdyPrev_q) irqSt_d[tsc_pkg::IRQ_TAPE_RDY] = 1'b1;
    if (scsiDone) irqSt_d[tsc_pkg::IRQ_SCSI_DONE] = 1'b1;
    if (parErr) irqSt_d[tsc_pkg::IRQ_PAR_ERR] = 1'b1;
    if (msgHit) irqSt_d[tsc_pkg::IRQ_MSG] = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      atn_q <= 1'b0; online_q <= 1'b0; tapeRst_q <= 1'b0; xferEn_q <= 1'b0;
      rdyIntEn_q <= 1'b0; rdyPrev_q <= 1'b0; excPrev_q <= 1'b0; excPend_q <= 1'b0;
      irqSt_q <= '0; rstCnt_q <= '0; favorTape_q <= 1'b0;
    end else begin
      atn_q <= atn_d; online_q <= online_d; tapeRst_q <= tapeRst_d; xferEn_q <= xferEn_d;
      rdyIntEn_q <= rdyIntEn_d; rdyPrev_q <= rdyS; excPrev_q <= excS;
      excPend_q <= excPend_d; irqSt_q <= irqSt_d; rstCnt_q <= rstCnt_d;
      favorTape_q <= favorTape_d;
    end
  end

  // ---------------------------------------------------------------------
  // scsi initiator, single initiator only, no arbitration phase
  // ---------------------------------------------------------------------
  logic [8:0] sDb_q, sDb_d;
  logic       sOe_q, sOe_d, sSel_q, sSel_d, sAck_q, sAck_d;
  logic [3:0] sCnt_q, sCnt_d;

  assign scsiDbOut = sDb_q;
  assign scsiDbOe  = sOe_q;
  assign scsiSel   = sSel_q;
  assign scsiAck   = sAck_q;
  assign scsiDone  = sSt_q == tsc_pkg::S_WAITREQ && !bsyS;
  assign parErr    = sGnt && sDbS[8] != oddPar(sDbS[7:0]);
  assign msgHit    = sSt_q == tsc_pkg::S_WAITREQ && bsyS && reqS && msgS && sAck_d;

  always_comb begin
    sSt_d = sSt_q; sDb_d = sDb_q; sOe_d = sOe_q;
    sSel_d = sSel_q; sAck_d = sAck_q; sCnt_d = sCnt_q;
    unique case (sSt_q)
      tsc_pkg::S_IDLE: if (selTake) begin
        sDb_d  = {oddPar(selId), selId};
        sOe_d  = 1'b1;
        sSel_d = 1'b1;
        sSt_d  = tsc_pkg::S_SEL;
      end
      tsc_pkg::S_SEL: if (bsyS) begin
        sSel_d = 1'b0;
        sOe_d  = 1'b0;
        sSt_d  = tsc_pkg::S_WAITREQ;
      end
      tsc_pkg::S_WAITREQ: begin
        if (!bsyS) begin
          sSt_d = tsc_pkg::S_IDLE;
        end else if (sGnt) begin
          sAck_d = 1'b1;
          sSt_d  = tsc_pkg::S_ACK;
        end else if (sOutNeed && dmaAck[0]) begin
          sDb_d  = {oddPar(dmaWrData), dmaWrData};
          sOe_d  = 1'b1;
          sCnt_d = 4'(tsc_pkg::INSTR_CYC);
          sSt_d  = tsc_pkg::S_SETUP;
        end
      end
      tsc_pkg::S_SETUP: begin
        sCnt_d = sCnt_q - 4'h1;
        if (sCnt_q == 4'h1) begin
          sAck_d = 1'b1;
          sSt_d  = tsc_pkg::S_ACK;
        end
      end
      tsc_pkg::S_ACK: if (!reqS) begin
        sAck_d = 1'b0;
        sOe_d  = 1'b0;
        sSt_d  = tsc_pkg::S_WAITREQ;
      end
    endcase
    if (rstCnt_q != '0) begin
      sSt_d = tsc_pkg::S_IDLE; sOe_d = 1'b0; sSel_d = 1'b0; sAck_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sSt_q <= tsc_pkg::S_IDLE; sDb_q <= '0; sOe_q <= 1'b0;
      sSel_q <= 1'b0; sAck_q <= 1'b0; sCnt_q <= '0;
    end else begin
      sSt_q <= sSt_d; sDb_q <= sDb_d; sOe_q <= sOe_d;
      sSel_q <= sSel_d; sAck_q <= sAck_d; sCnt_q <= sCnt_d;
    end
  end

  // ---------------------------------------------------------------------
  // tape host
  // ---------------------------------------------------------------------
  logic [7:0] tDb_q, tDb_d;
  logic       tOe_q, tOe_d, tReq_q, tReq_d, tXfer_q, tXfer_d;
  logic [3:0] tCnt_q, tCnt_d;

  assign tapeDbOut = tDb_q;
  assign tapeDbOe  = tOe_q && !dirS;
  assign tapeReq   = tReq_q;
  assign tapeXfer  = tXfer_q;

  always_comb begin
    tSt_d = tSt_q; tDb_d = tDb_q; tOe_d = tOe_q;
    tReq_d = tReq_q; tXfer_d = tXfer_q; tCnt_d = tCnt_q;
    unique case (tSt_q)
      tsc_pkg::T_IDLE: begin
        if (excPend_q && !tapeRst_q) begin
          tDb_d = tsc_pkg::TAPE_READ_STATUS;
          tOe_d = 1'b1;
          tSt_d = tsc_pkg::T_CMD;
        end else if (tCmdTake) begin
          tDb_d = tapeCmd;
          tOe_d = 1'b1;
          tSt_d = tsc_pkg::T_CMD;
        end else if (xferEn_q && rdyS && dirS && !tapeRst_q) begin
          tXfer_d = 1'b1;
          tSt_d   = tsc_pkg::T_RDACK;
        end else if (tOutNeed && dmaAck[1]) begin
          tDb_d  = dmaWrData;
          tOe_d  = 1'b1;
          tCnt_d = 4'(tsc_pkg::INSTR_CYC);
          tSt_d  = tsc_pkg::T_WRSET;
        end
      end
      tsc_pkg::T_CMD: if (rdyS) begin
        tReq_d = 1'b1;
        tSt_d  = tsc_pkg::T_CMDEND;
      end
      tsc_pkg::T_CMDEND: if (!rdyS) begin
        tReq_d = 1'b0;
        tOe_d  = 1'b0;
        tSt_d  = tsc_pkg::T_IDLE;
      end
      tsc_pkg::T_RDACK: if (tGnt) begin
        tXfer_d = 1'b0;
        tSt_d   = tsc_pkg::T_ACKLOW;
      end
      tsc_pkg::T_WRSET: begin
        tCnt_d = tCnt_q - 4'h1;
        if (tCnt_q == 4'h1) begin
          tXfer_d = 1'b1;
          tSt_d   = tsc_pkg::T_WRACK;
        end
      end
      tsc_pkg::T_WRACK: if (ackS) begin
        tXfer_d = 1'b0;
        tSt_d   = tsc_pkg::T_ACKLOW;
      end
      tsc_pkg::T_ACKLOW: if (!ackS) begin
        tOe_d = 1'b0;
        tSt_d = tsc_pkg::T_IDLE;
      end
      default: tSt_d = tsc_pkg::T_IDLE;
    endcase
    if (tapeRst_q) begin
      tSt_d = tsc_pkg::T_IDLE; tOe_d = 1'b0; tReq_d = 1'b0; tXfer_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tSt_q <= tsc_pkg::T_IDLE; tDb_q <= '0; tOe_q <= 1'b0;
      tReq_q <= 1'b0; tXfer_q <= 1'b0; tCnt_q <= '0;
    end else begin
      tSt_q <= tSt_d; tDb_q <= tDb_d; tOe_q <= tOe_d;
      tReq_q <= tReq_d; tXfer_q <= tXfer_d; tCnt_q <= tCnt_d;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_sel_until_bsy: assert property (@(posedge mclk) disable iff (sys_rst)
    scsiSel && !bsyS && rstCnt_q == '0 |=> scsiSel) else $error("SEL dropped early");
  a_ack_after_req: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(scsiAck) |-> $past(reqS)) else $error("ACK without REQ");
  a_rst_pulse_len: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(scsiRst) |-> ##RstLast scsiRst ##1 !scsiRst) else $error("RST pulse length");
  a_tape_req_rdy: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(tapeReq) |-> $past(rdyS) && tapeDbOut == $past(tapeDbOut))
    else $error("REQUEST without READY");
  a_exc_status: assert property (@(posedge mclk) disable iff (sys_rst)
    tSt_q == tsc_pkg::T_IDLE && excPend_q && !tapeRst_q
    |=> tSt_q == tsc_pkg::T_CMD && tapeDbOut == tsc_pkg::TAPE_READ_STATUS)
    else $error("no READ STATUS after exception");
  a_dir_oe_off: assert property (@(posedge mclk) disable iff (sys_rst)
    dirS |-> !tapeDbOe) else $error("tape bus driven against direction");
  a_online_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && cmdSel == tsc_pkg::CMD_XFER_EN && cmdSet |=> !tapeOnline)
    else $error("ON-LINE kept at transfer start");
  a_tape_rst_out: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && cmdSel == tsc_pkg::CMD_TAPE_RST |=> tapeRst == $past(cmdSet))
    else $error("tape RESET not following command");
  a_xfer_ack_pair: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(tapeXfer) && !$past(tapeRst_q) |-> $past(ackS)) else $error("TRANSFER without ACK");
  a_arb_alt: assert property (@(posedge mclk) disable iff (sys_rst)
    sPushReq && tPushReq && fq.inReady |-> (favorTape_q ? tGnt : sGnt) ##1 favorTape_q == $past(sGnt))
    else $error("channels not alternated");
  a_wait_busy: assert property (@(posedge mclk) disable iff (sys_rst)
    selWr && sSt_q != tsc_pkg::S_IDLE |-> asyncReadyWait) else $error("no wait while busy");
endmodule : tsc_ctrl

// [hw/tsc_pkg.sv]
// constants and state types of the tape/scsi dual channel controller
// assumes a single 40 MHz clock and an asynchronous active high reset
package tsc_pkg;
  // -------------------------------------------------------------------
  // timing and sizes
  // -------------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int INSTR_NS     = 50;
  localparam int INSTR_CYC    = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_CYC      = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH   = 16;
  localparam int FIFO_WIDTH   = 9;
  localparam int SYNC_W       = 26;
  // -------------------------------------------------------------------
  // processor command byte: bit 3 set/clear, bits 2:0 select; tape READ STATUS command byte
  // -------------------------------------------------------------------
  localparam int        CMD_SET_BIT   = 3;
  localparam logic [2:0] CMD_ATN      = 3'h0;
  localparam logic [2:0] CMD_SCSI_RST = 3'h1;
  localparam logic [2:0] CMD_ONLINE   = 3'h2;
  localparam logic [2:0] CMD_TAPE_RST = 3'h3;
  localparam logic [2:0] CMD_XFER_EN  = 3'h4;
  localparam logic [2:0] CMD_RDY_INT  = 3'h5;
  localparam logic [2:0] CMD_CLR_INT  = 3'h6;
  localparam logic [7:0] TAPE_READ_STATUS = 8'hC0;
  // -------------------------------------------------------------------
  // interrupt status bit positions
  // -------------------------------------------------------------------
  localparam int IRQ_SCSI_DONE = 0;
  localparam int IRQ_TAPE_EXC  = 1;
  localparam int IRQ_TAPE_RDY  = 2;
  localparam int IRQ_PAR_ERR   = 3;
  localparam int IRQ_MSG       = 4;
  localparam int IRQ_W         = 5;

  typedef enum logic [2:0] {S_IDLE, S_SEL, S_WAITREQ, S_SETUP, S_ACK} tsc_scsi_e;
  typedef enum logic [2:0] {T_IDLE, T_CMD, T_CMDEND, T_RDACK, T_WRSET, T_WRACK,
                            T_ACKLOW} tsc_tape_e;
endpackage : tsc_pkg

// [hw/tsc_fifo_if.sv]
// valid/ready carrier between the controller and its inbound byte fifo
// assumes producer and consumer on the same clock
`timescale 1ns/1ps
interface tsc_fifo_if #(parameter int WIDTH = 9);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;
  modport fifo (input inValid, inData, outReady, output inReady, outValid, outData);
  modport user (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface : tsc_fifo_if

// [hw/tsc_fifo.sv]
// synchronous fifo with registered read data
// assumes depth is a power of two
`timescale 1ns/1ps
module tsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // both sides
  tsc_fifo_if.fifo p
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic             push, pop;

  assign p.inReady  = cnt_q != (AW+1)'(DEPTH);
  assign p.outValid = cnt_q != '0;
  assign p.outData  = rd_q;
  assign push       = p.inValid && p.inReady;
  assign pop        = p.outValid && p.outReady;

  always_comb begin
    wp_d  = push ? wp_q + AW'(1) : wp_q;
    rp_d  = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    // bypass when the head entry is the one being written
    rd_d  = (push && wp_q == rp_d) ? p.inData : mem[rp_d];
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q] <= p.inData;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rd_q  <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rd_q  <= rd_d;
    end
  end
endmodule : tsc_fifo

// [test/tsc_far_end.sv]
// far-end model: one scsi target and one tape drive
// assumes the bench pulses sendByte only after the target is busy
`timescale 1ns/1ps
module tsc_far_end #(
  parameter logic [7:0] BYTE_VAL = 8'hA5
) (
  // clock
  input  wire logic       mclk,
  // scsi target
  input  wire logic       scsiSel,
  input  wire logic       scsiAck,
  input  wire logic       sendByte,
  output logic            scsiBsy,
  output logic            scsiReq,
  output logic            scsiIo,
  output logic            scsiMsg,
  output logic [8:0]      scsiDb,
  // tape drive
  input  wire logic       tapeReq,
  input  wire logic       tapeXfer,
  input  wire logic [7:0] tapeDbOut,
  input  wire logic       drvReady,
  output logic            tapeRdy,
  output logic            tapeAck,
  output logic [7:0]      tapeCmdSeen
);
  initial begin
    scsiBsy = 1'b0;
    scsiReq = 1'b0;
    scsiIo = 1'b0;
    scsiMsg = 1'b0;
    scsiDb = 9'h155;
    tapeRdy = 1'b0;
    tapeAck = 1'b0;
    tapeCmdSeen = 8'h00;
  end
  always @(posedge mclk) begin
    if (scsiSel) scsiBsy <= 1'b1;
    if (sendByte && scsiBsy) begin
      scsiIo <= 1'b1;
      scsiMsg <= 1'b1;
      scsiDb <= {~^BYTE_VAL, BYTE_VAL};
      scsiReq <= 1'b1;
    end else if (scsiReq && scsiAck) begin
      scsiReq <= 1'b0;
      scsiDb <= ~scsiDb;
    end
    tapeRdy <= drvReady;
    tapeAck <= tapeXfer;
    if (tapeReq) tapeCmdSeen <= tapeDbOut;
  end
endmodule : tsc_far_end

// [test/testbench.sv]
// self-checking bench for the tape/scsi dual channel controller
// assumes the far-end model stands in for the target and the drive
`timescale 1ns/1ps
module testbench;
  logic       mclk, sysRst, cmdWr, selWr, tapeCmdWr, sendByte, drvReady, tapeExcIn, tapeDirIn;
  logic [7:0] cmdByte, selId, tapeCmd, irqStatus, busStatus, dmaRdData, tapeDbOut, tapeCmdSeen;
  logic [1:0] dmaReq, dmaAck;
  logic [8:0] scsiDbOut, scsiDb;
  logic       asyncReadyWait, irq, scsiDbOe, scsiBsy, scsiReq, scsiIo, scsiSel, scsiAtn, scsiAck;
  logic       scsiRst, tapeDbOe, tapeRdy, tapeReq, tapeXfer, tapeOnline, tapeRst;
  logic       scsiMsg, tapeAck;
  int         errTotal, checksDone, n;
  tsc_ctrl uut (.mclk(mclk), .sys_rst(sysRst), .cmdWr(cmdWr), .cmdByte(cmdByte), .selWr(selWr),
    .selId(selId), .tapeCmdWr(tapeCmdWr), .tapeCmd(tapeCmd), .asyncReadyWait(asyncReadyWait),
    .irq(irq), .irqStatus(irqStatus), .busStatus(busStatus), .dmaReq(dmaReq), .dmaAck(dmaAck),
    .dmaWrData(8'h00), .dmaRdData(dmaRdData), .scsiDbIn(scsiDbOe ? scsiDbOut : scsiDb),
    .scsiDbOut(scsiDbOut), .scsiDbOe(scsiDbOe), .scsiBsyIn(scsiBsy), .scsiReqIn(scsiReq),
    .scsiIoIn(scsiIo), .scsiMsgIn(scsiMsg), .scsiCdIn(1'b0), .scsiSel(scsiSel), .scsiAtn(scsiAtn),
    .scsiAck(scsiAck), .scsiRst(scsiRst), .tapeDbIn(tapeDbOe ? tapeDbOut : 8'h5A),
    .tapeDbOut(tapeDbOut),
    .tapeDbOe(tapeDbOe), .tapeRdyIn(tapeRdy), .tapeExcIn(tapeExcIn), .tapeAckIn(tapeAck),
    .tapeDirIn(tapeDirIn), .tapeReq(tapeReq), .tapeXfer(tapeXfer), .tapeOnline(tapeOnline),
    .tapeRst(tapeRst));
  tsc_far_end far (.mclk(mclk), .scsiSel(scsiSel), .scsiAck(scsiAck), .sendByte(sendByte),
    .scsiBsy(scsiBsy), .scsiReq(scsiReq), .scsiIo(scsiIo), .scsiMsg(scsiMsg), .scsiDb(scsiDb),
    .tapeReq(tapeReq), .tapeXfer(tapeXfer), .tapeDbOut(tapeDbOut), .drvReady(drvReady),
    .tapeRdy(tapeRdy), .tapeAck(tapeAck), .tapeCmdSeen(tapeCmdSeen));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk);
    #2;
  endtask : tick
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic set, input logic [2:0] sel);
    cmdWr = 1'b1;
    cmdByte = {4'h0, set, sel};
    tick();
    cmdWr = 1'b0;
    tick();
  endtask : cmd
  task automatic waitTaken();
    n = 0;
    do @(posedge mclk); while (asyncReadyWait !== 1'b0 && ++n < 50);
    #2;
  endtask : waitTaken
  task automatic finishTest();
    if (errTotal == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finishTest
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic testControls();
    logic [2:0] sels [3] = '{tsc_pkg::CMD_ATN, tsc_pkg::CMD_ONLINE, tsc_pkg::CMD_TAPE_RST};
    for (int i = 0; i < 3; i++) begin
      cmd(1'b1, sels[i]);
      check(9'({scsiAtn, tapeOnline, tapeRst}), 9'(3'h4 >> i));
      cmd(1'b0, sels[i]);
      check(9'({scsiAtn, tapeOnline, tapeRst}), 9'h000);
    end
    cmd(1'b1, tsc_pkg::CMD_ONLINE);
    cmd(1'b1, tsc_pkg::CMD_XFER_EN);
    check(9'(tapeOnline), 9'h000);
    cmd(1'b0, tsc_pkg::CMD_XFER_EN);
    cmdWr = 1'b1;
    cmdByte = {5'h01, tsc_pkg::CMD_SCSI_RST};
    tick();
    cmdWr = 1'b0;
    n = 0;
    while (scsiRst === 1'b1 && n < 100) begin
      n++;
      tick();
    end
    check(9'(n), 9'(tsc_pkg::RST_CYC));
  endtask : testControls
  task automatic testScsi();
    selId = 8'h20;
    selWr = 1'b1;
    waitTaken();
    selWr = 1'b0;
    check({scsiSel, scsiDbOe, scsiDbOut[8:2]}, {2'b11, ~^selId, selId[7:2]});
    n = 0;
    while (scsiSel !== 1'b0 && n < 10) begin
      tick();
      n++;
    end
    check({6'h00, scsiBsy, scsiDbOe, 1'(n >= 2)}, 9'h005);
    sendByte = 1'b1;
    tick();
    sendByte = 1'b0;
    n = 0;
    while (dmaReq[0] !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check({1'b0, dmaRdData}, 9'h0A5);
    tick(4);
    check(9'({scsiReq, scsiAck}), 9'h000);
    dmaAck = 2'b01;
    tick();
    dmaAck = 2'b00;
    check(9'(dmaReq), 9'h000);
    check({1'b0, irqStatus}, 9'h010);
    check({1'b0, busStatus}, 9'h0B0);
  endtask : testScsi
  task automatic testTapeRead();
    drvReady = 1'b0;
    cmd(1'b1, tsc_pkg::CMD_XFER_EN);
    tapeDirIn = 1'b1;
    drvReady = 1'b1;
    n = 0;
    while (dmaReq[1] !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    check({dmaReq[1], dmaRdData}, 9'h15A);
    check(9'({tapeXfer, tapeDbOe}), 9'h000);
    dmaAck = 2'b10;
    tick();
    dmaAck = 2'b00;
    drvReady = 1'b0;
    check(9'(dmaReq), 9'h000);
    cmd(1'b0, tsc_pkg::CMD_XFER_EN);
  endtask : testTapeRead
  task automatic testTape();
    drvReady = 1'b1;
    tapeCmd = 8'h81;
    tapeCmdWr = 1'b1;
    waitTaken();
    tapeCmdWr = 1'b0;
    for (int pass = 0; pass < 2; pass++) begin
      n = 0;
      while (tapeReq !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      check({tapeDbOe, tapeDbOut}, {1'b1, pass ? tsc_pkg::TAPE_READ_STATUS : tapeCmd});
      tapeDirIn = 1'b1;
      tick(3);
      check(9'(tapeDbOe), 9'h000);
      tapeDirIn = 1'b0;
      drvReady = 1'b0;
      tick(8);
      check({tapeReq, tapeCmdSeen}, {1'b0, pass ? 8'hC0 : 8'h81});
      drvReady = 1'b1;
      tapeExcIn = 1'b1;
      tick(4);
      tapeExcIn = 1'b0;
    end
    check(9'({irq, irqStatus[tsc_pkg::IRQ_TAPE_EXC]}), 9'h003);
    cmd(1'b1, tsc_pkg::CMD_CLR_INT);
    check(9'(irq), 9'h000);
  endtask : testTape
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(25 * 5000);
    errTotal++;
    finishTest();
  end
  initial begin
    {sysRst, cmdWr, selWr, tapeCmdWr, sendByte, drvReady, tapeExcIn, tapeDirIn} = 8'h80;
    {cmdByte, selId, tapeCmd, dmaAck} = 26'h0;
    repeat (12) @(posedge mclk);
    #2;
    sysRst = 1'b0;
    tick(2);
    check({scsiSel, scsiAtn, scsiAck, scsiRst, tapeReq, tapeXfer, tapeOnline, tapeRst, irq}, 9'h0);
    testControls();
    testScsi();
    testTape();
    testTapeRead();
    finishTest();
  end
endmodule : testbench
